//--- bench/ssp_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_line_model (
  // Bit clocks
  output logic txClk,
  output logic rxClk,
  // Serial lines
  output logic rxd,
  input wire logic txd
);
  int halfNs = 32;
  // One rate generator feeds both directions and runs free
  initial begin
    txClk = 1'b1;
    rxd = 1'b1;
    forever #(halfNs) txClk = ~txClk;
  end
  assign rxClk = txClk;
  task automatic sendBits(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge rxClk);
      rxd = bits[i];
    end
  endtask : sendBits
  task automatic getFrame(output logic [9:0] frame, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    while (!ok && n < 40) begin
      @(posedge txClk);
      n++;
      ok = (txd === 1'b0);
    end
    frame[0] = txd;
    for (int i = 1; i < 10; i++) begin
      @(posedge txClk);
      frame[i] = txd;
    end
  endtask : getFrame
endmodule : ssp_line_model
`default_nettype wire

//--- bench/ssp_serial_port_props.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_serial_port_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // APB
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic txd,
  input wire logic dsrN,
  input wire logic rtsN,
  input wire logic dtrN,
  input wire logic syncDetectPinOut,
  input wire logic syncDetectPinOe,
  input wire logic transmitterEmpty
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic ctrlWr, dataWr, rdCtrl, dsrPrev_q;
  logic [1:0] wrCnt_q;
  logic [3:0] dsrAge_q;
  assign ctrlWr = psel && penable && pready && pwrite && (paddr == ssp_pkg::ADDR_CTRL);
  assign dataWr = psel && penable && pready && pwrite && (paddr == ssp_pkg::ADDR_DATA);
  assign rdCtrl = psel && penable && pready && !pwrite && (paddr == ssp_pkg::ADDR_CTRL);
  // Status bit only trusted once the pin has settled past the synchroniser
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wrCnt_q <= 2'h0;
      dsrAge_q <= 4'h0;
      dsrPrev_q <= 1'b0;
    end else begin
      dsrPrev_q <= dsrN;
      if (ctrlWr && wrCnt_q != 2'h2) begin
        wrCnt_q <= wrCnt_q + 2'h1;
      end
      if (dsrN != dsrPrev_q) begin
        dsrAge_q <= 4'h0;
      end else if (dsrAge_q != 4'hF) begin
        dsrAge_q <= dsrAge_q + 4'h1;
      end
    end
  end
  sequence sSetup;
    psel && !penable;
  endsequence
  sequence sAccess;
    psel && penable;
  endsequence
  chk_one_wait: assert property (sSetup ##1 sAccess |=> pready)
    else $error("pready not after one wait state");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_bad_addr: assert property (pready && paddr != ssp_pkg::ADDR_DATA && paddr != ssp_pkg::ADDR_CTRL |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_rts_cause: assert property ($changed(rtsN) |-> $past(ctrlWr) || $past(ctrlWr, 2))
    else $error("rts moved without control write");
  chk_dtr_cause: assert property ($changed(dtrN) |-> $past(ctrlWr) || $past(ctrlWr, 2))
    else $error("dtr moved without control write");
  chk_empty_drop: assert property ($fell(transmitterEmpty) |-> $past(dataWr) || $past(dataWr, 2))
    else $error("empty fell without data load");
  chk_txd_setup: assert property (!txd |-> wrCnt_q == 2'h2)
    else $error("txd left mark before setup");
  chk_dsr_status: assert property (rdCtrl && dsrAge_q > 4'h7 |-> prdata[7] == !dsrN)
    else $error("status dsr bit wrong");
  chk_brk_status: assert property (rdCtrl && syncDetectPinOe && $stable(syncDetectPinOut) |-> prdata[6] == syncDetectPinOut)
    else $error("status bit 6 differs from pin");
  chk_reset_idle: assert property ($rose(rstn) |-> txd && rtsN && dtrN && transmitterEmpty && !syncDetectPinOut)
    else $error("outputs not idle after reset");
endmodule : ssp_serial_port_props
bind ssp_serial_port ssp_serial_port_props u_props (.clk_sys(clk_sys), .rstn(rstn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .txd(txd), .dsrN(dsrN), .rtsN(rtsN), .dtrN(dtrN), .syncDetectPinOut(syncDetectPinOut),
  .syncDetectPinOe(syncDetectPinOe), .transmitterEmpty(transmitterEmpty));
`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [11:0] A_CT = ssp_pkg::ADDR_CTRL;
  localparam logic [11:0] A_DT = ssp_pkg::ADDR_DATA;
  localparam int SYN = 3;
  localparam int TXE = 2;
  localparam int RXR = 0;
  logic clk_sys, rstn, psel, penable, pwrite, ctsN, dsrN, pready, pslverr, rerr, ok;
  logic txClk, rxClk, rxd, txd, rtsN, dtrN, synOut, synOe, transmitter_empty, rxReady, synIn;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [9:0] frame;
  logic [3:0] mon;
  int n_mismatch, n_tests;
  assign mon = {synOut, transmitter_empty, txd, rxReady};
  ssp_serial_port u_dut (.clk_sys(clk_sys), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .transmitBitClock(txClk), .receiveBitClock(rxClk), .rxd(rxd), .txd(txd), .ctsN(ctsN), .dsrN(dsrN),
    .rtsN(rtsN), .dtrN(dtrN), .syncDetectPinIn(synIn), .syncDetectPinOut(synOut), .syncDetectPinOe(synOe),
    .transmitterEmpty(transmitter_empty), .rxReady(rxReady));
  ssp_line_model u_line (.txClk(txClk), .rxClk(rxClk), .rxd(rxd), .txd(txd));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : check
  // Entered just after a rising edge; leaves one idle cycle behind it
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h000000, d};
    psel <= 1'b1;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
    check(n < 50, 1'b1);
    if (n >= 50) begin
      test_done();
    end
  endtask : apb
  task automatic waitMon(input int i, input logic v, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (mon[i] !== v && n < lim);
    check(mon[i], v);
    // A wait that ran out ends the run at once
    if (mon[i] !== v) begin
      test_done();
    end
  endtask : waitMon
  task automatic test_done();
    if (n_mismatch == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end
  initial begin
    n_mismatch = 0;
    n_tests = 0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    ctsN = 1'b1;
    dsrN = 1'b0;
    synIn = 1'b0;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    check({txd, rtsN, dtrN, transmitter_empty, synOe, synOut}, 6'h3E);
    apb(12'h008, 1'b0, 8'h00);
    check({rerr, rdat}, 33'h100000000);
    apb(A_CT, 1'b1, 8'h4D);
    apb(A_CT, 1'b1, 8'h23);
    check({rtsN, dtrN, txd}, 3'b001);
    apb(A_DT, 1'b1, 8'h55);
    check(transmitter_empty, 1'b0);
    // CTS still high: the loaded character must wait
    repeat (400) @(posedge clk_sys);
    check(txd, 1'b1);
    ctsN <= 1'b0;
    u_line.getFrame(frame, ok);
    check({ok, frame}, {1'b1, 1'b1, 8'h55, 1'b0});
    if (!ok) begin
      test_done();
    end
    waitMon(TXE, 1'b1, 400);
    apb(A_CT, 1'b0, 8'h00);
    check({rdat[7], rdat[2]}, 2'b11);
    dsrN <= 1'b1;
    repeat (8) @(posedge clk_sys);
    apb(A_CT, 1'b0, 8'h00);
    check(rdat[7], 1'b0);
    apb(A_CT, 1'b1, 8'h00);
    apb(A_DT, 1'b1, 8'hA5);
    check({transmitter_empty, rtsN, dtrN}, 3'b011);
    repeat (400) @(posedge clk_sys);
    check(txd, 1'b1);
    apb(A_CT, 1'b1, 8'h40);
    check({txd, transmitter_empty, rtsN}, 3'b111);
    apb(A_CT, 1'b1, 8'h4D);
    apb(A_CT, 1'b1, 8'h04);
    // Sixteen low bits is short of two ten-bit characters
    u_line.sendBits(16'h0000, 16);
    @(posedge rxClk);
    repeat (8) @(posedge clk_sys);
    check(synOut, 1'b0);
    waitMon(SYN, 1'b1, 400);
    apb(A_CT, 1'b0, 8'h00);
    check({rdat[6], synOut}, 2'b11);
    u_line.sendBits(16'hFFFF, 1);
    waitMon(SYN, 1'b0, 100);
    apb(A_CT, 1'b1, 8'h40);
    u_line.halfNs = 96;
    apb(A_CT, 1'b1, 8'h0C);
    apb(A_CT, 1'b1, 8'h16);
    apb(A_CT, 1'b1, 8'h16);
    apb(A_CT, 1'b1, 8'h84);
    u_line.sendBits(16'h0016, 8);
    @(posedge rxClk);
    repeat (12) @(posedge clk_sys);
    check({synOe, synOut}, 2'b10);
    u_line.sendBits(16'h0016, 8);
    @(posedge rxClk);
    waitMon(SYN, 1'b1, 20);
    apb(A_CT, 1'b0, 8'h00);
    check(rdat[6], 1'b1);
    check(synOut, 1'b0);
    ////////////////////////////////////////////////////////////////////////////
    // External sync, single sync character: pin turns input, fillers follow data
    apb(A_CT, 1'b1, 8'h40);
    apb(A_CT, 1'b1, 8'hCC);
    apb(A_CT, 1'b1, 8'h16);
    apb(A_CT, 1'b1, 8'h25);
    check(synOe, 1'b0);
    apb(A_DT, 1'b1, 8'h3C);
    waitMon(TXE, 1'b1, 800);
    // First filler on the line right after the data character
    u_line.getFrame(frame, ok);
    check({ok, frame, transmitter_empty}, {1'b1, 10'h216, 1'b1});
    if (!ok) begin
      test_done();
    end
    // Sync pin held high over a full receive clock period, then eight data bits
    @(negedge rxClk);
    @(posedge clk_sys);
    synIn <= 1'b1;
    u_line.sendBits(16'h00A5, 8);
    @(posedge rxClk);
    @(posedge clk_sys);
    synIn <= 1'b0;
    waitMon(RXR, 1'b1, 20);
    apb(A_DT, 1'b0, 8'h00);
    check({rdat[7:0], rxReady}, {8'hA5, 1'b0});
    test_done();
  end
endmodule : tb_top
`default_nettype wire

//--- core/ssp_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_pin_sync (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Raw pins
  input wire logic [5:0] pinIn,
  // Synchronised view
  output logic [5:0] pinLevel,
  output logic [5:0] pinRise,
  output logic [5:0] pinFall
);
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] s3;
  } ssp_sync_t;

  ssp_sync_t s;
  ssp_sync_t n;

  always_comb begin
    n.s1 = pinIn;
    n.s2 = s.s1;
    n.s3 = s.s2;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s <= {ssp_pkg::PIN_RST, ssp_pkg::PIN_RST, ssp_pkg::PIN_RST};
    end else begin
      s <= n;
    end
  end

  // Edges look only at the second and third stage
  assign pinLevel = s.s2;
  assign pinRise = s.s2 & ~s.s3;
  assign pinFall = ~s.s2 & s.s3;
endmodule : ssp_pin_sync
`default_nettype wire

//--- core/ssp_pkg.sv
package ssp_pkg;
  // APB byte addresses
  localparam logic [11:0] ADDR_DATA = 12'h000;
  localparam logic [11:0] ADDR_CTRL = 12'h004;

  // Mode word fields
  localparam int MODE_FACT_LSB = 0;
  localparam int MODE_LEN_LSB = 2;
  localparam int MODE_PEN = 4;
  localparam int MODE_PEVEN = 5;
  localparam int MODE_EXTSYNC = 6;
  localparam int MODE_SINGLE = 7;
  localparam int MODE_STOP_LSB = 6;
  localparam logic [1:0] FACT_SYNC = 2'h0;
  localparam logic [1:0] FACT_X16 = 2'h2;
  localparam logic [1:0] FACT_X64 = 2'h3;
  localparam logic [1:0] STOP_ONE = 2'h1;

  // Command word fields
  localparam int CMD_TRANSMIT_ENABLE_BIT = 0;
  localparam int CMD_DTR = 1;
  localparam int CMD_RXE = 2;
  localparam int CMD_BRK = 3;
  localparam int CMD_ERR = 4;
  localparam int CMD_RTS = 5;
  localparam int CMD_IR = 6;
  localparam int CMD_HUNT = 7;

  // Status word fields
  localparam int ST_TXRDY = 0;
  localparam int ST_RXRDY = 1;
  localparam int ST_TRANSMITTER_EMPTY = 2;
  localparam int ST_OVERRUN = 4;
  localparam int ST_SYNBRK = 6;
  localparam int ST_DSR = 7;

  // Reset values and timing
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [11:0] BREAK_CHARS = 12'h002;
  localparam logic [5:0] PIN_RST = 6'h3F;

  typedef enum logic [1:0] {
    SEQ_MODE = 2'b00,
    SEQ_SYNC1 = 2'b01,
    SEQ_SYNC2 = 2'b10,
    SEQ_CMD = 2'b11
  } ssp_seq_t;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_SYNC2 = 2'b01,
    RX_DATA = 2'b10
  } ssp_rx_t;
endpackage : ssp_pkg

//--- core/ssp_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_serial_port (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial link
  input wire logic transmitBitClock,
  input wire logic receiveBitClock,
  input wire logic rxd,
  output logic txd,
  // Modem control
  input wire logic ctsN,
  input wire logic dsrN,
  output logic rtsN,
  output logic dtrN,
  // Sync detect / break detect pin
  input wire logic syncDetectPinIn,
  output logic syncDetectPinOut,
  output logic syncDetectPinOe,
  // Status pins
  output logic transmitterEmpty,
  output logic rxReady
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    ssp_pkg::ssp_seq_t seq;
    logic [7:0] mode;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] cmd;
    logic pready;
    logic pslverr;
    logic [7:0] prdata;
    logic [7:0] txBuf;
    logic txFull;
    logic [11:0] txShift;
    logic [3:0] txBits;
    logic [6:0] txTick;
    logic txBusy;
    logic txFiller;
    logic fillOk;
    logic fillSecond;
    logic txd;
    logic transmitter_empty;
    ssp_pkg::ssp_rx_t rxSt;
    logic [7:0] rxShift;
    logic [3:0] rxBits;
    logic [7:0] rxData;
    logic rxRdy;
    logic overrun;
    logic syncDet;
    logic breakDetect;
    logic [11:0] lowCnt;
    logic syncOut;
    logic syncOe;
    logic rtsN;
    logic dtrN;
  } ssp_state_t;

  localparam ssp_state_t RST_STATE = '{
    seq: ssp_pkg::SEQ_MODE,
    rxSt: ssp_pkg::RX_HUNT,
    mode: ssp_pkg::MODE_RST,
    cmd: ssp_pkg::CMD_RST,
    txd: 1'b1,
    transmitter_empty: 1'b1,
    syncOe: 1'b1,
    rtsN: 1'b1,
    dtrN: 1'b1,
    default: '0
  };

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] charLen(input logic [7:0] m);
    charLen = 4'h5 + {2'h0, m[ssp_pkg::MODE_LEN_LSB +: 2]};
  endfunction : charLen

  function automatic logic isSync(input logic [7:0] m);
    isSync = m[ssp_pkg::MODE_FACT_LSB +: 2] == ssp_pkg::FACT_SYNC;
  endfunction : isSync

  function automatic logic [6:0] facTicks(input logic [7:0] m);
    unique case (m[ssp_pkg::MODE_FACT_LSB +: 2])
      ssp_pkg::FACT_X16: facTicks = 7'h10;
      ssp_pkg::FACT_X64: facTicks = 7'h40;
      default: facTicks = 7'h01;
    endcase
  endfunction : facTicks

  // Total bits in one character frame on the line
  function automatic logic [3:0] frameBits(input logic [7:0] m);
    logic [3:0] b;
    b = charLen(m) + {3'h0, m[ssp_pkg::MODE_PEN]};
    if (!isSync(m)) begin
      b = b + ((m[ssp_pkg::MODE_STOP_LSB +: 2] == ssp_pkg::STOP_ONE) ? 4'h2 : 4'h3);
    end
    frameBits = b;
  endfunction : frameBits

  // Frame in send order, bit 0 first; unused upper bits are stop level
  function automatic logic [11:0] txFrame(input logic [7:0] d, input logic [7:0] m);
    logic [11:0] f;
    logic [3:0] len;
    logic [3:0] off;
    logic p;
    f = 12'hFFF;
    len = charLen(m);
    off = isSync(m) ? 4'h0 : 4'h1;
    p = ~m[ssp_pkg::MODE_PEVEN];
    if (!isSync(m)) begin
      f[0] = 1'b0;
    end
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < len) begin
        f[off + 4'(i)] = d[i];
        p = p ^ d[i];
      end
    end
    if (m[ssp_pkg::MODE_PEN]) begin
      f[off + len] = p;
    end
    txFrame = f;
  endfunction : txFrame

  function automatic logic [7:0] rxAlign(input logic [7:0] sh, input logic [7:0] m);
    rxAlign = sh >> (4'h8 - charLen(m));
  endfunction : rxAlign

  function automatic logic [7:0] charMask(input logic [7:0] c, input logic [7:0] m);
    charMask = c & ~(8'hFF << charLen(m));
  endfunction : charMask

  ////////////////////////////////////////////////////////////////////////////
  logic [5:0] pinLevel;
  logic [5:0] pinRise;
  logic [5:0] pinFall;

  // Bit clocks, line and modem pins are sampled on clk_sys
  ssp_pin_sync u_pin_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pinIn({syncDetectPinIn, dsrN, ctsN, rxd, receiveBitClock, transmitBitClock}),
    .pinLevel(pinLevel),
    .pinRise(pinRise),
    .pinFall(pinFall)
  );

  logic txFall;
  logic rxRise;
  logic rxLine;
  logic ctsLvl;
  logic dsrLvl;
  logic syncInLvl;
  assign txFall = pinFall[0];
  assign rxRise = pinRise[1];
  assign rxLine = pinLevel[2];
  assign ctsLvl = pinLevel[3];
  assign dsrLvl = pinLevel[4];
  assign syncInLvl = pinLevel[5];

  ssp_state_t s;
  ssp_state_t n;

  ////////////////////////////////////////////////////////////////////////////
  logic acc;
  logic hitData;
  logic hitCtrl;
  logic irHit;
  logic permit;
  logic [7:0] statusWord;
  logic [7:0] curChar;
  logic [7:0] newShift;
  logic [11:0] frame;

  always_comb begin
    n = s;
    irHit = 1'b0;
    frame = 12'h000;
    hitData = paddr == ssp_pkg::ADDR_DATA;
    hitCtrl = paddr == ssp_pkg::ADDR_CTRL;
    acc = psel & penable & s.pready;

    statusWord = 8'h00;
    statusWord[ssp_pkg::ST_TXRDY] = ~s.txFull;
    statusWord[ssp_pkg::ST_RXRDY] = s.rxRdy;
    statusWord[ssp_pkg::ST_TRANSMITTER_EMPTY] = s.transmitter_empty;
    statusWord[ssp_pkg::ST_OVERRUN] = s.overrun;
    statusWord[ssp_pkg::ST_SYNBRK] = s.syncOut;
    statusWord[ssp_pkg::ST_DSR] = ~dsrLvl;

    // One wait state: answer in the second access cycle
    n.pready = psel & penable & ~s.pready;
    if (psel & penable & ~s.pready) begin
      n.pslverr = ~(hitData | hitCtrl);
      n.prdata = hitCtrl ? statusWord : (hitData ? s.rxData : 8'h00);
    end

    // Bus side effects first, so hardware sets below win
    if (acc & pwrite & hitCtrl) begin
      unique case (s.seq)
        ssp_pkg::SEQ_MODE: begin
          n.mode = pwdata[7:0];
          n.seq = isSync(pwdata[7:0]) ? ssp_pkg::SEQ_SYNC1 : ssp_pkg::SEQ_CMD;
        end
        ssp_pkg::SEQ_SYNC1: begin
          n.sync1 = pwdata[7:0];
          n.seq = s.mode[ssp_pkg::MODE_SINGLE] ? ssp_pkg::SEQ_CMD : ssp_pkg::SEQ_SYNC2;
        end
        ssp_pkg::SEQ_SYNC2: begin
          n.sync2 = pwdata[7:0];
          n.seq = ssp_pkg::SEQ_CMD;
        end
        ssp_pkg::SEQ_CMD: begin
          if (pwdata[ssp_pkg::CMD_IR]) begin
            irHit = 1'b1;
          end else begin
            n.cmd = pwdata[7:0];
            if (pwdata[ssp_pkg::CMD_ERR]) begin
              n.overrun = 1'b0;
            end
            if (pwdata[ssp_pkg::CMD_HUNT]) begin
              n.rxSt = ssp_pkg::RX_HUNT;
            end
          end
        end
      endcase
    end
    if (acc & pwrite & hitData) begin
      n.txBuf = pwdata[7:0];
      n.txFull = 1'b1;
    end
    if (acc & ~pwrite & hitCtrl) begin
      n.syncDet = 1'b0;
    end
    if (acc & ~pwrite & hitData) begin
      n.rxRdy = 1'b0;
    end

    // Transmitter, stepped on falling bit clock edges
    permit = s.cmd[ssp_pkg::CMD_TRANSMIT_ENABLE_BIT] & ~ctsLvl;
    if (txFall) begin
      if (s.txBusy) begin
        if (s.txTick != 7'h00) begin
          n.txTick = s.txTick - 7'h01;
        end else if (s.txBits != 4'h1) begin
          n.txShift = s.txShift >> 1;
          n.txBits = s.txBits - 4'h1;
          n.txTick = facTicks(s.mode) - 7'h01;
        end else begin
          n.txBusy = 1'b0;
          n.txFiller = 1'b0;
        end
      end
      // Next character starts on the same edge the last one ends
      if (!n.txBusy && permit && s.seq == ssp_pkg::SEQ_CMD) begin
        if (n.txFull) begin
          frame = txFrame(n.txBuf, s.mode);
          n.txFull = 1'b0;
          n.fillOk = isSync(s.mode);
          n.fillSecond = 1'b0;
          n.txFiller = 1'b0;
          n.txBusy = 1'b1;
        end else if (isSync(s.mode) && s.fillOk) begin
          frame = txFrame(s.fillSecond ? s.sync2 : s.sync1, s.mode);
          n.fillSecond = ~s.fillSecond & ~s.mode[ssp_pkg::MODE_SINGLE];
          n.txFiller = 1'b1;
          n.txBusy = 1'b1;
        end
        if (n.txBusy) begin
          n.txShift = frame;
          n.txBits = frameBits(s.mode);
          n.txTick = facTicks(s.mode) - 7'h01;
        end
      end
    end
    n.transmitter_empty = ~n.txFull & (~n.txBusy | n.txFiller);

    // Receiver, sampled on rising bit clock edges
    newShift = {rxLine, s.rxShift[7:1]};
    curChar = rxAlign(newShift, s.mode);
    if (rxRise && isSync(s.mode) && s.seq == ssp_pkg::SEQ_CMD) begin
      n.rxShift = newShift;
      unique case (s.rxSt)
        ssp_pkg::RX_HUNT: begin
          if (s.mode[ssp_pkg::MODE_EXTSYNC]) begin
            n.rxShift = s.rxShift;
            if (syncInLvl) begin
              n.syncDet = 1'b1;
              n.rxSt = ssp_pkg::RX_DATA;
              n.rxBits = 4'h0;
            end
          end else if (curChar == charMask(s.sync1, s.mode)) begin
            n.rxBits = 4'h0;
            if (s.mode[ssp_pkg::MODE_SINGLE]) begin
              n.syncDet = 1'b1;
              n.rxSt = ssp_pkg::RX_DATA;
            end else begin
              n.rxSt = ssp_pkg::RX_SYNC2;
            end
          end
        end
        ssp_pkg::RX_SYNC2: begin
          n.rxBits = s.rxBits + 4'h1;
          if (n.rxBits == charLen(s.mode)) begin
            n.rxBits = 4'h0;
            if (curChar == charMask(s.sync2, s.mode)) begin
              n.syncDet = 1'b1;
              n.rxSt = ssp_pkg::RX_DATA;
            end else begin
              n.rxSt = ssp_pkg::RX_HUNT;
            end
          end
        end
        ssp_pkg::RX_DATA: begin
          n.rxBits = s.rxBits + 4'h1;
          if (n.rxBits == charLen(s.mode)) begin
            n.rxBits = 4'h0;
            n.rxData = curChar;
            if (s.cmd[ssp_pkg::CMD_RXE]) begin
              n.overrun = n.overrun | n.rxRdy;
              n.rxRdy = 1'b1;
            end
          end
        end
        default: begin
          n.rxSt = ssp_pkg::RX_HUNT;
        end
      endcase
    end

    // Break detect: count low receive clock edges over two frames
    if (rxLine) begin
      n.lowCnt = 12'h000;
      n.breakDetect = 1'b0;
    end else if (rxRise && !isSync(s.mode) && s.seq == ssp_pkg::SEQ_CMD) begin
      if (s.lowCnt != 12'hFFF) begin
        n.lowCnt = s.lowCnt + 12'h001;
      end
      if (n.lowCnt >= ssp_pkg::BREAK_CHARS * {5'h00, facTicks(s.mode)} * {8'h00, frameBits(s.mode)}) begin
        n.breakDetect = 1'b1;
      end
    end

    n.syncOe = ~isSync(s.mode) | ~s.mode[ssp_pkg::MODE_EXTSYNC];
    n.syncOut = isSync(s.mode) ? n.syncDet : n.breakDetect;
    n.rtsN = ~n.cmd[ssp_pkg::CMD_RTS];
    n.dtrN = ~n.cmd[ssp_pkg::CMD_DTR];
    // Break level overrides, otherwise mark when idle
    n.txd = n.cmd[ssp_pkg::CMD_BRK] ? 1'b0 : (n.txBusy ? n.txShift[0] : 1'b1);

    if (irHit) begin
      n = RST_STATE;
      n.pready = 1'b0;
    end
  end

  // Receiver and break detect idle until the mode word and any sync characters arrive, transmitter until the command word
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s <= RST_STATE;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign prdata = {24'h000000, s.prdata};
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign txd = s.txd;
  assign rtsN = s.rtsN;
  assign dtrN = s.dtrN;
  assign syncDetectPinOut = s.syncOut;
  assign syncDetectPinOe = s.syncOe;
  assign transmitterEmpty = s.transmitter_empty;
  assign rxReady = s.rxRdy;
endmodule : ssp_serial_port
`default_nettype wire
